// *** inc/sd_cfg_pkg.sv ***
// Purpose: shared constants for the SD host function configuration header front registers
// Assumes: 32-bit configuration dwords with byte enables, one clock domain
// Notes:   byte offsets are the printed ones; the dword index drops the low two bits
`default_nettype none
package sd_cfg_pkg;

  // configuration access widths
  localparam int unsigned  DW_ADDR_W      = 6;
  localparam int unsigned  DATA_W         = 32;
  localparam int unsigned  BE_W           = 4;
  localparam int unsigned  REG_W          = 16;

  // byte offsets of the four registers
  localparam logic [7:0]   OFF_MAKER_CODE    = 8'h00;
  localparam logic [7:0]   OFF_PART_CODE     = 8'h02;
  localparam logic [7:0]   OFF_BUS_CONTROL   = 8'h04;
  localparam logic [7:0]   OFF_BUS_CONDITION = 8'h06;

  // dword indices derived from the byte offsets
  localparam logic [5:0]   DW_IDENT       = OFF_MAKER_CODE[7:2];
  localparam logic [5:0]   DW_CTRL        = OFF_BUS_CONTROL[7:2];

  // identification values: arbitrary neutral values
  localparam logic [15:0]  MAKER_CODE     = 16'ha5c3;
  localparam logic [15:0]  PART_CODE      = 16'h5a3c;

  // bus_control field positions
  localparam int unsigned  CTL_INT_MASK   = 10;
  localparam int unsigned  CTL_BTB        = 9;
  localparam int unsigned  CTL_SERR       = 8;
  localparam int unsigned  CTL_STEP       = 7;
  localparam int unsigned  CTL_PERR       = 6;
  localparam int unsigned  CTL_PALETTE    = 5;
  localparam int unsigned  CTL_WINV       = 4;
  localparam int unsigned  CTL_SPECIAL    = 3;
  localparam int unsigned  CTL_INITIATOR  = 2;
  localparam int unsigned  CTL_MEMSPACE   = 1;
  localparam int unsigned  CTL_PORTSPACE  = 0;

  // bus_control reset value and writable bits
  localparam logic [15:0]  CTL_RESET      = 16'h0000;
  localparam logic [15:0]  CTL_WR_MASK    = 16'h0546;

  // bus_condition field positions
  localparam int unsigned  STS_PAR_DET    = 15;
  localparam int unsigned  STS_SYS_ERR    = 14;
  localparam int unsigned  STS_ABORT      = 13;
  localparam int unsigned  STS_TABT_RX    = 12;
  localparam int unsigned  STS_TABT_SIG   = 11;
  localparam int unsigned  STS_DATAPAR    = 8;
  localparam int unsigned  STS_CAP        = 4;
  localparam int unsigned  STS_INT        = 3;

  // bus_condition reset value, fixed bits and clearable bits
  localparam logic [15:0]  STS_RESET      = 16'h0210;
  localparam logic [15:0]  STS_FIXED      = 16'h0210;
  localparam logic [15:0]  STS_CLR_MASK   = 16'hf900;

endpackage
`default_nettype wire

// *** logic/sticky_flag.sv ***
// Purpose: one status flag set by hardware and cleared by a write of one
// Assumes: set and clear come from logic on the same clock
// Notes:   a set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ns
`default_nettype none
module sticky_flag (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic next_flag;

  // set wins over clear
  assign next_flag = set_i | (flag_o & ~clear_i); // RULE16

  // synchronous reset to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule
`default_nettype wire

// *** logic/sd_host_pci_config_header.sv ***
// Purpose: front of the configuration header of the SD host function: ids, bus_control, bus_condition
// Assumes: configuration accesses arrive as 32-bit dwords with byte enables, same clock as the core
// Notes:   every output is registered; gated outputs follow their causes by one cycle, int_n_o two cycles after irq_cond_i
// Functional notes
// RULE1 - maker_code at offset 00h reads a fixed 16-bit value; writes ignored.
// RULE2 - part_code at offset 02h reads a fixed 16-bit value; writes ignored.
// RULE3 - bus_control sits at offset 04h and resets to all zeros.
// RULE4 - bus_control bits 15 to 11 always read zero.
// RULE5 - bus_control bit 10 set blocks interrupt assertion; clear allows it.
// RULE6 - bus_control bit 9 reads zero; no back-to-back generation.
// RULE7 - bus_control bit 8 enables the system error driver.
// RULE8 - bus_control bit 7 is hardwired zero; no stepping.
// RULE9 - bus_control bit 6 enables driving parity error responses.
// RULE10 - bus_control bit 5 reads zero; no palette snooping.
// RULE11 - bus_control bit 4 reads zero; no write-and-invalidate.
// RULE12 - bus_control bit 3 reads zero; special cycles ignored.
// RULE13 - bus mastering happens only while bus_control bit 2 is one.
// RULE14 - memory cycles are claimed only while bus_control bit 1 is one.
// RULE15 - bus_control bit 0 reads zero; port space never claimed.
// RULE16 - writing one clears a status flag; writing zero leaves it.
// RULE17 - bus_condition sits at offset 06h and resets to 0210h.
// RULE18 - bus_condition bits 10 and 9 read 01b, medium select timing.
// RULE19 - bus_condition bit 4 reads one; capability chain present.
// RULE20 - bit 3 follows the enabled interrupt condition; line asserts if unmasked.
// RULE21 - bus_condition bit 13 sets when an own cycle ends in master abort.
// RULE22 - writes to fixed bits leave them unchanged; readback shows fixed values.
`timescale 1ns/1ns
`default_nettype none
module sd_host_pci_config_header (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // configuration access port
  input  wire logic                              cfg_sel_i,
  input  wire logic                              cfg_wr_i,
  input  wire logic [sd_cfg_pkg::DW_ADDR_W-1:0]  cfg_dword_i,
  input  wire logic [sd_cfg_pkg::BE_W-1:0]       cfg_be_i,
  input  wire logic [sd_cfg_pkg::DATA_W-1:0]     cfg_wdata_i,
  output logic      [sd_cfg_pkg::DATA_W-1:0]     cfg_rdata_o,
  output logic                                   cfg_ack_o,
  // events and requests from the bus engine and the SD core
  input  wire logic                              irq_cond_i,
  input  wire logic                              addr_par_err_i,
  input  wire logic                              data_par_err_i,
  input  wire logic                              perr_seen_as_master_i,
  input  wire logic                              master_abort_i,
  input  wire logic                              target_abort_rx_i,
  input  wire logic                              target_abort_sig_i,
  input  wire logic                              master_req_i,
  input  wire logic                              mem_hit_i,
  // gated controls toward the bus engine
  output logic                                   int_n_o,
  output logic                                   serr_drive_o,
  output logic                                   perr_drive_o,
  output logic                                   bus_req_o,
  output logic                                   mem_claim_o,
  output logic                                   back_to_back_gen_on_o,
  output logic                                   stepping_ctrl_o,
  output logic                                   palette_snoop_on_o,
  output logic                                   write_invalidate_on_o,
  output logic                                   portspace_response_on_o
);

  import sd_cfg_pkg::*;

  // writable control bits and the interrupt status
  logic                 int_mask;
  logic                 system_error_drive_on;
  logic                 parity_report_on;
  logic                 initiator_on;
  logic                 memspace_response_on;
  logic                 int_pending;

  // status flag vector
  wire  [REG_W-1:0]     sticky;
  logic [REG_W-1:0]     set_vec;
  logic [REG_W-1:0]     clr_vec;

  // views of the two registers
  wire  [REG_W-1:0]     ctrl_view;
  wire  [REG_W-1:0]     cond_view;
  wire  [DATA_W-1:0]    rd_word;

  // access decode
  wire                  hit_ident;
  wire                  hit_ctrl;
  wire                  wr_ctrl;
  wire                  wr_ctrl_lo;
  wire                  wr_ctrl_hi;
  wire                  wr_cond_hi;
  wire  [REG_W-1:0]     ctrl_wdata;
  wire  [REG_W-1:0]     cond_wdata;
  wire  [REG_W-1:0]     next_ctrl;

  logic                 capability_chain_present;
  logic                 initiator_abort_seen;

  // dword decode of configuration accesses
  assign hit_ident  = cfg_sel_i && (cfg_dword_i == DW_IDENT);
  assign hit_ctrl   = cfg_sel_i && (cfg_dword_i == DW_CTRL);
  assign wr_ctrl    = hit_ctrl && cfg_wr_i;
  assign wr_ctrl_lo = wr_ctrl && cfg_be_i[0];
  assign wr_ctrl_hi = wr_ctrl && cfg_be_i[1];
  assign wr_cond_hi = wr_ctrl && cfg_be_i[3];
  assign ctrl_wdata = cfg_wdata_i[15:0];
  assign cond_wdata = cfg_wdata_i[31:16];

  // bus_control readback: only the five writable bits can show a one
  assign ctrl_view = {5'h00,                          // RULE4
                      int_mask,                       // RULE5
                      1'b0,                           // RULE6
                      system_error_drive_on,          // RULE7
                      1'b0,                           // RULE8
                      parity_report_on,               // RULE9
                      1'b0,                           // RULE10
                      1'b0,                           // RULE11
                      1'b0,                           // RULE12
                      initiator_on,                   // RULE13
                      memspace_response_on,           // RULE14
                      1'b0};                          // RULE15

  // fixed status bits
  assign capability_chain_present = STS_FIXED[STS_CAP]; // RULE19
  assign initiator_abort_seen     = sticky[STS_ABORT];

  // bus_condition readback: sticky flags, fixed bits, live interrupt status
  assign cond_view = (sticky & STS_CLR_MASK)
                   | (STS_FIXED & ~(16'h0001 << STS_CAP))              // RULE17 RULE18 RULE22
                   | ({15'h0000, capability_chain_present} << STS_CAP) // RULE19
                   | (int_pending ? (16'h0001 << STS_INT) : 16'h0000); // RULE20

  // read mux; unmapped dwords read zero
  assign rd_word = hit_ident ? {PART_CODE, MAKER_CODE} :     // RULE1 RULE2
                   hit_ctrl  ? {cond_view, ctrl_view}  :     // RULE3 RULE17
                               32'h0000_0000;

  // byte-lane write merge of the writable control bits only
  assign next_ctrl = {wr_ctrl_hi ? ctrl_wdata[15:8] : ctrl_view[15:8],
                      wr_ctrl_lo ? ctrl_wdata[7:0]  : ctrl_view[7:0]} & CTL_WR_MASK; // RULE22

  // control register update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask              <= CTL_RESET[CTL_INT_MASK];  // RULE3
      system_error_drive_on <= CTL_RESET[CTL_SERR];
      parity_report_on      <= CTL_RESET[CTL_PERR];
      initiator_on          <= CTL_RESET[CTL_INITIATOR];
      memspace_response_on  <= CTL_RESET[CTL_MEMSPACE];
    end else begin
      int_mask              <= next_ctrl[CTL_INT_MASK];
      system_error_drive_on <= next_ctrl[CTL_SERR];
      parity_report_on      <= next_ctrl[CTL_PERR];
      initiator_on          <= next_ctrl[CTL_INITIATOR];
      memspace_response_on  <= next_ctrl[CTL_MEMSPACE];
    end
  end

  // set sources of the sticky status flags
  always_comb begin
    set_vec               = 16'h0000;
    set_vec[STS_PAR_DET]  = addr_par_err_i | data_par_err_i;
    set_vec[STS_SYS_ERR]  = serr_drive_o;                          // set once signalled
    set_vec[STS_ABORT]    = master_abort_i;                        // RULE21
    set_vec[STS_TABT_RX]  = target_abort_rx_i;
    set_vec[STS_TABT_SIG] = target_abort_sig_i;
    set_vec[STS_DATAPAR]  = perr_seen_as_master_i & parity_report_on;
  end

  // write-one-to-clear in the high status byte
  assign clr_vec = wr_cond_hi ? (cond_wdata & STS_CLR_MASK) : 16'h0000; // RULE16

  // one sticky cell per clearable bit, constant zero elsewhere
  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi++) begin : g_sts
      if (STS_CLR_MASK[gi]) begin : g_cell
        sticky_flag u_flag (
          .clk_i   (clk_i),
          .rst_i   (rst_i),
          .set_i   (set_vec[gi]),
          .clear_i (clr_vec[gi]),
          .flag_o  (sticky[gi])
        );
      end else begin : g_zero
        assign sticky[gi] = STS_RESET[gi] & STS_CLR_MASK[gi];
      end
    end
  endgenerate

  // configuration answer: data and ack one cycle after the access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_ack_o   <= 1'b0;
    end else begin
      cfg_rdata_o <= (cfg_sel_i && !cfg_wr_i) ? rd_word : 32'h0000_0000;
      cfg_ack_o   <= cfg_sel_i;
    end
  end

  // interrupt status tracks the enabled condition; line is low active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_pending <= 1'b0;
      int_n_o     <= 1'b1;
    end else begin
      int_pending <= irq_cond_i;                      // RULE20
      int_n_o     <= ~(int_pending & ~int_mask);      // RULE5 RULE20
    end
  end

  // gated controls toward the bus engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serr_drive_o <= 1'b0;
      perr_drive_o <= 1'b0;
      bus_req_o    <= 1'b0;
      mem_claim_o  <= 1'b0;
    end else begin
      serr_drive_o <= addr_par_err_i & system_error_drive_on; // RULE7
      perr_drive_o <= data_par_err_i & parity_report_on;      // RULE9
      bus_req_o    <= master_req_i & initiator_on;            // RULE13
      mem_claim_o  <= mem_hit_i & memspace_response_on;       // RULE14
    end
  end

  // unsupported features stay off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      back_to_back_gen_on_o   <= 1'b0;
      stepping_ctrl_o         <= 1'b0;
      palette_snoop_on_o      <= 1'b0;
      write_invalidate_on_o   <= 1'b0;
      portspace_response_on_o <= 1'b0;
    end else begin
      back_to_back_gen_on_o   <= ctrl_view[CTL_BTB];       // RULE6
      stepping_ctrl_o         <= ctrl_view[CTL_STEP];      // RULE8
      palette_snoop_on_o      <= ctrl_view[CTL_PALETTE];   // RULE10
      write_invalidate_on_o   <= ctrl_view[CTL_WINV];      // RULE11
      portspace_response_on_o <= ctrl_view[CTL_PORTSPACE]; // RULE15
    end
  end

  // identity reads return the fixed codes even after writes
  chk_ident_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    (cfg_sel_i && !cfg_wr_i && cfg_dword_i == DW_IDENT) |=> (cfg_rdata_o[15:0] == MAKER_CODE))
    else $error("maker code readback wrong");

  chk_part_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    (cfg_sel_i && !cfg_wr_i && cfg_dword_i == DW_IDENT) |=> (cfg_rdata_o[31:16] == PART_CODE))
    else $error("part code readback wrong");

  // reset values of both registers
  chk_ctrl_reset: assert property (@(posedge clk_i) // RULE3
    $past(rst_i) |-> (ctrl_view == CTL_RESET))
    else $error("bus_control not zero after reset");

  chk_cond_reset: assert property (@(posedge clk_i) // RULE17
    $past(rst_i) |-> ((cond_view & ~(16'h0001 << STS_INT)) == STS_RESET))
    else $error("bus_condition reset value wrong");

  // hardwired control bits never read back as one
  chk_ctrl_fixed: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4 RULE6 RULE8 RULE10
    (cfg_sel_i && !cfg_wr_i && cfg_dword_i == DW_CTRL) |=> ((cfg_rdata_o[15:0] & ~CTL_WR_MASK) == 16'h0000))
    else $error("hardwired control bit reads one");

  chk_unsupported_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11 RULE12 RULE15
    ##1 !(portspace_response_on_o || write_invalidate_on_o || ctrl_view[CTL_SPECIAL]))
    else $error("unsupported feature enabled");

  // fixed status bits read as documented
  chk_cond_fixed: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18 RULE19 RULE22
    (cfg_sel_i && !cfg_wr_i && cfg_dword_i == DW_CTRL)
    |=> (cfg_rdata_o[26:25] == 2'b01) && cfg_rdata_o[20] && (cfg_rdata_o[18:16] == 3'b000))
    else $error("fixed status bits wrong");

  // interrupt line only when status bit set and unmasked
  chk_int_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5 RULE20
    !int_n_o |-> $past(int_pending && !int_mask))
    else $error("interrupt asserted while masked or idle");

  chk_int_follow: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    (irq_cond_i && !int_mask) ##1 !int_mask |=> !int_n_o)
    else $error("interrupt not asserted");

  // error drivers gated by their enables
  chk_serr_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    serr_drive_o |-> $past(system_error_drive_on && addr_par_err_i))
    else $error("serr driven while disabled");

  chk_perr_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    perr_drive_o |-> $past(parity_report_on && data_par_err_i))
    else $error("perr driven while disabled");

  // master request gated; memory hit claimed while memory response is on
  chk_master_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    bus_req_o |-> $past(master_req_i && initiator_on))
    else $error("bus request while mastering off");

  chk_mem_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    (mem_hit_i && memspace_response_on) |=> mem_claim_o)
    else $error("memory hit not claimed");

  // sticky abort flag: set by abort, cleared by write of one only
  chk_abort_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
    master_abort_i |=> initiator_abort_seen)
    else $error("master abort not recorded");

  chk_abort_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    (wr_cond_hi && cond_wdata[STS_ABORT] && !master_abort_i) |=> !initiator_abort_seen)
    else $error("write of one did not clear");

  chk_abort_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    (initiator_abort_seen && !(wr_cond_hi && cond_wdata[STS_ABORT])) |=> initiator_abort_seen)
    else $error("status flag lost without clear");

  // control writes land per byte lane; other cycles keep the bits
  chk_ctrl_lo_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9 RULE13 RULE14
    wr_ctrl_lo |=> ((ctrl_view[7:0] & CTL_WR_MASK[7:0]) == $past(cfg_wdata_i[7:0] & CTL_WR_MASK[7:0])))
    else $error("low control byte write lost");

  chk_ctrl_hi_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5 RULE7
    wr_ctrl_hi |=> ((ctrl_view[15:8] & CTL_WR_MASK[15:8]) == $past(cfg_wdata_i[15:8] & CTL_WR_MASK[15:8])))
    else $error("high control byte write lost");

  chk_ctrl_keep: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    (!wr_ctrl_lo && !wr_ctrl_hi) |=> $stable(ctrl_view))
    else $error("control bits changed without write");

  // mask forces the line high; status bit reads the live interrupt level
  chk_int_block: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    int_mask |=> int_n_o)
    else $error("interrupt asserted while masked");

  chk_int_status: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    (cfg_sel_i && !cfg_wr_i && cfg_dword_i == DW_CTRL)
    |=> (cfg_rdata_o[REG_W + STS_INT] == $past(int_pending)))
    else $error("interrupt status readback wrong");

  // master request and memory claim follow their enables both ways
  chk_master_follow: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (master_req_i && initiator_on) |=> bus_req_o)
    else $error("bus request not raised");

  chk_mem_block: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    !memspace_response_on |=> !mem_claim_o)
    else $error("memory claimed while response off");

  // a write of one clears every flag unless a set lands in the same cycle
  chk_flags_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    wr_cond_hi |=> ((sticky & $past(cond_wdata & STS_CLR_MASK & ~set_vec)) == 16'h0000))
    else $error("status flag not cleared");

endmodule
`default_nettype wire

// *** verif/cfg_host_model.sv ***
// Purpose: host bridge side issuing configuration reads and writes to the header
// Assumes: one access in flight, launched and released on the falling edge
// Notes:   released lines carry the inverse of their last value, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
  input  wire logic        clk_i,
  output logic             cfg_sel_o,
  output logic             cfg_wr_o,
  output logic [5:0]       cfg_dword_o,
  output logic [3:0]       cfg_be_o,
  output logic [31:0]      cfg_wdata_o,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        cfg_ack_i
);
  // idle pattern until the first access
  initial begin
    cfg_sel_o   = 1'b0;
    cfg_wr_o    = 1'b0;
    cfg_dword_o = 6'h3f;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h5a5a_a5a5;
  end

  // request stands for one rising edge, answer taken in the cycle after
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ack);
    @(negedge clk_i);
    cfg_sel_o   = 1'b1;
    cfg_wr_o    = wr;
    cfg_dword_o = dw;
    cfg_be_o    = be;
    cfg_wdata_o = wd;
    @(negedge clk_i);
    rd          = cfg_rdata_i;
    ack         = cfg_ack_i;
    cfg_sel_o   = 1'b0;
    cfg_wr_o    = ~wr;
    cfg_dword_o = ~dw;
    cfg_be_o    = ~be;
    cfg_wdata_o = ~wd;
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the configuration header front registers
// Assumes: inputs change on the falling edge, outputs sampled a half cycle after they update
// Notes:   random control writes from a fixed seed, corner cases for byte lanes and flags
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sd_cfg_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        sel;
  logic        wr;
  logic [5:0]  dw;
  logic [3:0]  be;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [31:0] rdata;
  logic        ack;
  logic        ack_seen;
  logic [5:0]  evt;
  logic        irq;
  logic        mreq;
  logic        mhit;
  logic        int_n;
  logic        serr;
  logic        perr;
  logic        breq;
  logic        mclaim;
  wire  [4:0]  fixed;
  logic [15:0] ctrl_exp;
  logic [31:0] v;
  logic [3:0]  b;
  logic [15:0] c;
  int          err_total;
  int          check_count;
  int          cycles;
  integer      seed;
  logic [5:0]  ev_tab [4] = '{6'b000100, 6'b000010, 6'b000001, 6'b011000};
  logic [15:0] bit_tab [4] = '{16'h2000, 16'h1000, 16'h0800, 16'h8100};

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  cfg_host_model host (.clk_i(clk_i), .cfg_sel_o(sel), .cfg_wr_o(wr), .cfg_dword_o(dw), .cfg_be_o(be),
    .cfg_wdata_o(wd), .cfg_rdata_i(rdata), .cfg_ack_i(ack));

  sd_host_pci_config_header dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_sel_i(sel), .cfg_wr_i(wr),
    .cfg_dword_i(dw), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
    .irq_cond_i(irq), .addr_par_err_i(evt[5]), .data_par_err_i(evt[4]), .perr_seen_as_master_i(evt[3]),
    .master_abort_i(evt[2]), .target_abort_rx_i(evt[1]), .target_abort_sig_i(evt[0]),
    .master_req_i(mreq), .mem_hit_i(mhit), .int_n_o(int_n), .serr_drive_o(serr), .perr_drive_o(perr),
    .bus_req_o(breq), .mem_claim_o(mclaim), .back_to_back_gen_on_o(fixed[4]), .stepping_ctrl_o(fixed[3]),
    .palette_snoop_on_o(fixed[2]), .write_invalidate_on_o(fixed[1]), .portspace_response_on_o(fixed[0]));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one access through the host, acknowledge always expected
  task automatic rw(input logic w, input logic [5:0] d, input logic [3:0] e, input logic [31:0] x);
    host.access(w, d, e, x, rd, ack_seen);
    check({31'h0, ack_seen}, 32'h1);
  endtask

  // event pulse for one rising edge
  task automatic fire(input logic [5:0] x);
    @(negedge clk_i);
    evt = x;
    @(negedge clk_i);
    evt = 6'h00;
  endtask

  // writable control bits are 10, 8, 6, 2 and 1, per byte lane
  function automatic logic [15:0] next_ctrl(input logic [15:0] old, input logic [15:0] w, input logic [1:0] e);
    logic [15:0] m;
    m = {{8{e[1]}}, {8{e[0]}}} & 16'h0546;
    return (old & ~m) | (w & m);
  endfunction

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end

  // main sequence
  initial begin
    seed = 32'h7b43;
    rst_i = 1'b1;
    evt = 6'h00;
    irq = 1'b0;
    mreq = 1'b0;
    mhit = 1'b0;
    err_total = 0;
    check_count = 0;
    cycles = 0;
    ctrl_exp = 16'h0000;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    // reset values and identification words
    rw(1'b0, 6'h01, 4'hf, 32'h0);
    check(rd, 32'h0210_0000);
    rw(1'b1, 6'h00, 4'hf, 32'hffff_ffff);
    rw(1'b0, 6'h00, 4'hf, 32'h0);
    check(rd, {PART_CODE, MAKER_CODE});
    rw(1'b0, 6'h2a, 4'hf, 32'h0);
    check(rd, 32'h0);
    // random control writes with byte lanes, fixed bits must hold
    for (int i = 0; i < 14; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $random(seed);
      b = (i == 0) ? 4'hf : v[19:16];
      rw(1'b1, 6'h01, b, {16'h0000, v[15:0]});
      ctrl_exp = next_ctrl(ctrl_exp, v[15:0], b[1:0]);
      rw(1'b0, 6'h01, 4'hf, 32'h0);
      check(rd, {16'h0210, ctrl_exp});
      check({27'h0, fixed}, 32'h0);
    end
    // gated outputs, then parity flags and their clearing
    for (int j = 0; j < 2; j++) begin
      c = (j == 0) ? 16'h0000 : 16'h0546;
      rw(1'b1, 6'h01, 4'h3, {16'h0000, c});
      @(negedge clk_i);
      mreq = 1'b1;
      mhit = 1'b1;
      evt = 6'b110000;
      @(negedge clk_i);
      check({28'h0, serr, perr, breq, mclaim}, {28'h0, c[8], c[6], c[2], c[1]});
      mreq = 1'b0;
      mhit = 1'b0;
      evt = 6'h00;
      rw(1'b0, 6'h01, 4'hf, 32'h0);
      check(rd, {16'h8210 | (c[8] ? 16'h4000 : 16'h0000), c});
      rw(1'b1, 6'h01, 4'hc, 32'hffff_0000);
      rw(1'b0, 6'h01, 4'hf, 32'h0);
      check(rd, {16'h0210, c});
    end
    // each event flag: zero write keeps it, one write clears it
    for (int k = 0; k < 4; k++) begin
      fire(ev_tab[k]);
      rw(1'b1, 6'h01, 4'h8, 32'h0);
      rw(1'b0, 6'h01, 4'hf, 32'h0);
      check(rd, {16'h0210 | bit_tab[k], 16'h0546});
      rw(1'b1, 6'h01, 4'hc, {bit_tab[k], 16'h0000});
      rw(1'b0, 6'h01, 4'hf, 32'h0);
      check(rd, {16'h0210, 16'h0546});
    end
    // interrupt with mask clear and set
    for (int m = 0; m < 2; m++) begin
      rw(1'b1, 6'h01, 4'h3, {16'h0000, (m == 1) ? 16'h0546 : 16'h0146});
      @(negedge clk_i);
      irq = 1'b1;
      repeat (2) @(negedge clk_i);
      check({31'h0, int_n}, m);
      rw(1'b0, 6'h01, 4'hf, 32'h0);
      check(rd[31:16], 32'h0218);
      irq = 1'b0;
      repeat (2) @(negedge clk_i);
      check({31'h0, int_n}, 32'h1);
    end
    results();
  end
endmodule
`default_nettype wire
